// >>> core/mbt_pkg.sv
// Shared constants for the register-server frame link.
// ****************************************************************
// Operation
// ****************************************************************
// Operation
// [R1] Master picks any transaction identifier per query
// [R2] Server echoes transaction identifier unchanged
// [R3] Protocol id zero; nonzero gets no reply
// [R4] Length counts unit id through last byte
// [R5] Unit id 0 or 255 only, echoed
// [R6] Function code 06 writes one register
// [R7] Address equals register number minus 40001
// [R8] Write value field is exactly two bytes
// [R9] Write reply echoes the whole query
// [R10] Writes allowed across holding register area; server writes only addresses below NUM_REGS and drops the rest
// [R11] Two-byte fields travel high byte first
// [R12] Read count at most 125 registers
// [R13] Read byte count is twice register count
// [R14] Read values ascend, high byte first
package mbt_pkg;
   localparam logic [7:0] FC_READ = 8'h03;
   localparam logic [7:0] FC_WRITE = 8'h06;
   localparam logic [7:0] UNIT_ANY = 8'h00;
   localparam logic [7:0] UNIT_ALL = 8'hFF;
   localparam logic [15:0] PROTO_ID = 16'h0000;
   localparam logic [15:0] REG_BASE = 16'h9C41;
   localparam logic [15:0] MAX_READ = 16'h007D;
   localparam logic [15:0] REQ_LEN = 16'h0006;
   localparam int HDR_BYTES = 7;
   localparam int REQ_BYTES = 12;
   localparam logic [15:0] RSP_LEN_BASE = 16'h0003;
endpackage

// >>> core/mbt_if.sv
// Byte-stream link between the master and the register server.
`timescale 1ns/1ps
interface mbt_if;
   logic [7:0] q_data;
   logic q_valid;
   logic q_ready;
   logic [7:0] r_data;
   logic r_valid;
   logic r_last;
   logic r_ready;
   modport server (input q_data, input q_valid, output q_ready,
                   output r_data, output r_valid, output r_last, input r_ready);
   modport master (output q_data, output q_valid, input q_ready,
                   input r_data, input r_valid, input r_last, output r_ready);
endinterface

// >>> core/mbt_server.sv
// Register server end: parses queries, writes or reads registers, answers.
`timescale 1ns/1ps
module mbt_server
   import mbt_pkg::*;
#(
   parameter int NUM_REGS = 256
) (
   input wire logic sys_clk, // System clock.
   input wire logic reset, // Synchronous reset, active high.
   mbt_if.server link, // Frame link to the master.
   output logic wr_strobe, // One-cycle pulse on a register write.
   output logic [15:0] wr_addr, // Address of the written register.
   output logic [15:0] wr_data // Value written.
);
   // ****************************************************************
   // State and storage
   // ****************************************************************

   typedef enum logic [1:0] {
      S_RECV = 2'b00,
      S_EVAL = 2'b01,
      S_SEND = 2'b10
   } state_t;

   state_t state_q, state_d;
   logic [7:0] qbuf_q [REQ_BYTES];
   logic [7:0] qbuf_d [REQ_BYTES];
   logic [3:0] idx_q, idx_d;
   logic [8:0] ocnt_q, ocnt_d;
   logic [8:0] olen_q, olen_d;
   logic is_read_q, is_read_d;
   logic [15:0] regs_q [NUM_REGS];
   logic [7:0] out_q, out_d;
   logic wr_q, wr_d;
   logic [15:0] fa, fv;
   logic [15:0] regs_d [NUM_REGS];

   // ****************************************************************
   // Query fields
   // ****************************************************************

   // Fields are gathered high byte first.
   assign fa = {qbuf_q[8], qbuf_q[9]}; // R11
   assign fv = {qbuf_q[10], qbuf_q[11]}; // R8

   // ****************************************************************
   // Answer bytes
   // ****************************************************************

   // True when an address falls inside the implemented register array.
   function automatic logic in_range(input logic [15:0] a);
      in_range = (a < 16'(NUM_REGS));
   endfunction

   // Byte of the answer at a given position; headers are mostly echoed.
   function automatic logic [7:0] rsp_byte(input logic [8:0] p);
      logic [15:0] len;
      logic [15:0] ra;
      logic [15:0] rv;
      len = RSP_LEN_BASE + {7'h00, fv[8:0]} * 16'd2; // R4
      ra = fa + 16'({7'h00, p - 9'd9} >> 1); // R14
      // Words past the array read as zero rather than wrapping onto low addresses.
      rv = in_range(ra) ? regs_q[ra[7:0]] : 16'h0000;
      if (!is_read_q) begin
         rsp_byte = qbuf_q[p[3:0]]; // R9
      end else begin
         case (p)
            9'd0, 9'd1, 9'd6, 9'd7: rsp_byte = qbuf_q[p[3:0]]; // R2
            9'd2: rsp_byte = PROTO_ID[15:8]; // R3
            9'd3: rsp_byte = PROTO_ID[7:0];
            9'd4: rsp_byte = len[15:8];
            9'd5: rsp_byte = len[7:0];
            9'd8: rsp_byte = {fv[6:0], 1'b0}; // R13
            default: rsp_byte = p[0] ? rv[15:8] : rv[7:0]; // R14
         endcase
      end
   endfunction

   // ****************************************************************
   // Link outputs
   // ****************************************************************

   // Handshakes come straight from the state; the answer byte comes from a flip-flop.
   // Ready stays low while a query is judged, so a second query simply waits.
   assign link.q_ready = (state_q == S_RECV);
   assign link.r_valid = (state_q == S_SEND);
   assign link.r_data = out_q;
   assign link.r_last = (state_q == S_SEND) && (ocnt_q == olen_q - 9'd1);
   assign wr_strobe = wr_q;
   assign wr_addr = fa;
   assign wr_data = fv;

   // ****************************************************************
   // Frame sequencing
   // ****************************************************************

   // Next state: collect twelve bytes, judge the query, stream the answer.
   // The next answer byte is prepared when the current one is taken, so the
   // byte on the link never changes while it is still being offered.
   always_comb begin
      state_d = state_q;
      qbuf_d = qbuf_q;
      idx_d = idx_q;
      ocnt_d = ocnt_q;
      olen_d = olen_q;
      is_read_d = is_read_q;
      out_d = out_q;
      wr_d = 1'b0;
      case (state_q)
         S_RECV: begin
            if (link.q_valid) begin
               qbuf_d[idx_q] = link.q_data;
               if (idx_q == 4'(REQ_BYTES - 1)) begin
                  idx_d = 4'h0;
                  state_d = S_EVAL;
               end else begin
                  idx_d = idx_q + 4'h1;
               end
            end
         end
         S_EVAL: begin
            // Bad queries are dropped silently; no exception frame here.
            // The master cannot tell a drop from a slow answer, so it must be reset.
            state_d = S_RECV;
            if ({qbuf_q[2], qbuf_q[3]} == PROTO_ID && // R3
                {qbuf_q[4], qbuf_q[5]} == REQ_LEN && // R4
                (qbuf_q[6] == UNIT_ANY || qbuf_q[6] == UNIT_ALL)) begin // R5
               if (qbuf_q[7] == FC_WRITE && in_range(fa)) begin // R6
                  wr_d = 1'b1; // R10
                  is_read_d = 1'b0;
                  olen_d = 9'(REQ_BYTES);
                  ocnt_d = 9'd0;
                  out_d = qbuf_q[0];
                  state_d = S_SEND;
               end else if (qbuf_q[7] == FC_READ && fv != 16'h0000 && fv <= MAX_READ) begin // R12
                  is_read_d = 1'b1;
                  olen_d = 9'd9 + {fv[7:0], 1'b0};
                  ocnt_d = 9'd0;
                  out_d = qbuf_q[0];
                  state_d = S_SEND;
               end
            end
         end
         S_SEND: begin
            if (link.r_ready) begin
               if (ocnt_q == olen_q - 9'd1) begin
                  state_d = S_RECV;
               end else begin
                  ocnt_d = ocnt_q + 9'd1;
                  out_d = rsp_byte(ocnt_q + 9'd1);
               end
            end
         end
         default: state_d = S_RECV;
      endcase
   end

   // ****************************************************************
   // Frame registers
   // ****************************************************************

   // Registers the frame state; the register array has its own pair of processes.
   // Every register has a constant reset value, applied on the clock edge.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_q <= S_RECV;
         idx_q <= 4'h0;
         ocnt_q <= 9'd0;
         olen_q <= 9'd0;
         is_read_q <= 1'b0;
         out_q <= 8'h00;
         wr_q <= 1'b0;
         for (int i = 0; i < REQ_BYTES; i++) begin
            qbuf_q[i] <= 8'h00;
         end
      end else begin
         state_q <= state_d;
         qbuf_q <= qbuf_d;
         idx_q <= idx_d;
         ocnt_q <= ocnt_d;
         olen_q <= olen_d;
         is_read_q <= is_read_d;
         out_q <= out_d;
         wr_q <= wr_d;
      end
   end

   // ****************************************************************
   // Register storage
   // ****************************************************************

   // Next array contents: only a judged write changes one word.
   always_comb begin
      regs_d = regs_q;
      if (wr_q) begin
         regs_d[fa[7:0]] = fv; // R6
      end
   end

   // Register storage; written one cycle after the query is judged.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            regs_q[i] <= 16'h0000;
         end
      end else begin
         regs_q <= regs_d;
      end
   end
endmodule

// >>> core/mbt_master.sv
// Master end: serialises one query and collects the answer bytes.
`timescale 1ns/1ps
module mbt_master
   import mbt_pkg::*;
(
   input wire logic sys_clk, // System clock.
   input wire logic reset, // Synchronous reset, active high.
   mbt_if.master link, // Frame link to the server.
   input wire logic req_valid, // Start a query, level.
   output logic req_ready, // Idle and able to take a query.
   input wire logic req_write, // 1 = write one register, 0 = read.
   input wire logic [15:0] req_tid, // Transaction identifier.
   input wire logic [7:0] req_unit, // Unit identifier.
   input wire logic [15:0] req_reg, // Holding register number, decimal value.
   input wire logic [15:0] req_val, // Write value or read count.
   output logic [7:0] rsp_data, // Answer byte.
   output logic rsp_valid, // Answer byte strobe.
   output logic rsp_last // Last answer byte.
);
   typedef enum logic [1:0] {
      M_IDLE = 2'b00,
      M_SEND = 2'b01,
      M_WAIT = 2'b10
   } state_t;

   state_t state_q, state_d;
   logic [7:0] frm_q [REQ_BYTES];
   logic [7:0] frm_d [REQ_BYTES];
   logic [3:0] idx_q, idx_d;
   logic [7:0] rdat_q, rdat_d;
   logic rval_q, rval_d;
   logic rlast_q, rlast_d;
   logic [15:0] addr;

   assign addr = req_reg - REG_BASE; // R7
   assign req_ready = (state_q == M_IDLE);
   assign link.q_valid = (state_q == M_SEND);
   assign link.q_data = frm_q[idx_q];
   assign link.r_ready = 1'b1;
   assign rsp_data = rdat_q;
   assign rsp_valid = rval_q;
   assign rsp_last = rlast_q;

   // Builds the frame high byte first, then sends it and waits for the end.
   always_comb begin
      state_d = state_q;
      frm_d = frm_q;
      idx_d = idx_q;
      rdat_d = link.r_data;
      rval_d = link.r_valid;
      rlast_d = link.r_valid && link.r_last;
      case (state_q)
         M_IDLE: begin
            if (req_valid) begin
               frm_d[0] = req_tid[15:8]; // R1
               frm_d[1] = req_tid[7:0];
               frm_d[2] = PROTO_ID[15:8]; // R3
               frm_d[3] = PROTO_ID[7:0];
               frm_d[4] = REQ_LEN[15:8]; // R4
               frm_d[5] = REQ_LEN[7:0];
               frm_d[6] = req_unit;
               frm_d[7] = req_write ? FC_WRITE : FC_READ; // R6
               frm_d[8] = addr[15:8]; // R11
               frm_d[9] = addr[7:0];
               frm_d[10] = req_val[15:8]; // R8
               frm_d[11] = req_val[7:0]; // R12
               idx_d = 4'h0;
               state_d = M_SEND;
            end
         end
         M_SEND: begin
            if (link.q_ready) begin
               if (idx_q == 4'(REQ_BYTES - 1)) begin
                  state_d = M_WAIT;
               end else begin
                  idx_d = idx_q + 4'h1;
               end
            end
         end
         M_WAIT: begin
            // A dropped query gets no answer; the user resets to recover.
            if (link.r_valid && link.r_last) begin
               state_d = M_IDLE;
            end
         end
         default: state_d = M_IDLE;
      endcase
   end

   // Registers the master state.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_q <= M_IDLE;
         idx_q <= 4'h0;
         rdat_q <= 8'h00;
         rval_q <= 1'b0;
         rlast_q <= 1'b0;
         for (int i = 0; i < REQ_BYTES; i++) begin
            frm_q[i] <= 8'h00;
         end
      end else begin
         state_q <= state_d;
         frm_q <= frm_d;
         idx_q <= idx_d;
         rdat_q <= rdat_d;
         rval_q <= rval_d;
         rlast_q <= rlast_d;
      end
   end
endmodule

// >>> tb/mbt_assertions.sv
// Checker for the query and answer byte streams.
`timescale 1ns/1ps
module mbt_assertions
   import mbt_pkg::*;
(
   input wire logic sys_clk, // Clock.
   input wire logic reset, // Reset.
   input wire logic [7:0] q_data, // Query byte.
   input wire logic q_valid, // Query valid.
   input wire logic q_ready, // Query ready.
   input wire logic [7:0] r_data, // Answer byte.
   input wire logic r_valid, // Answer valid.
   input wire logic r_last, // Answer end.
   input wire logic r_ready // Answer accept.
);
   logic [3:0] qc_q, qc_d;
   logic [7:0] qb_q [12];
   logic [7:0] qb_d [12];
   logic [8:0] rc_q, rc_d;
   logic [7:0] ln_q, ln_d;
   // Keep the last query and the answer byte index, so echoes can be judged.
   always_comb begin
      qc_d = qc_q;
      qb_d = qb_q;
      rc_d = rc_q;
      ln_d = ln_q;
      if (q_valid && q_ready) begin
         qb_d[qc_q] = q_data;
         qc_d = (qc_q == 4'hB) ? 4'h0 : qc_q + 4'h1;
      end
      if (r_valid && r_ready) begin
         rc_d = r_last ? 9'h000 : rc_q + 9'h001;
         if (rc_q == 9'h005) ln_d = r_data;
      end
      if (reset) begin
         qc_d = 4'h0;
         rc_d = 9'h000;
      end
   end
   // Registers only.
   always_ff @(posedge sys_clk) begin
      qc_q <= qc_d;
      qb_q <= qb_d;
      rc_q <= rc_d;
      ln_q <= ln_d;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   property p_tid; r_valid && rc_q < 9'h002 |-> r_data == qb_q[rc_q[3:0]]; endproperty
   a_tid: assert property (p_tid) else $error("Transaction id not echoed.");
   property p_zero; r_valid && rc_q inside {[2:4]} |-> r_data == 8'h00; endproperty
   a_zero: assert property (p_zero) else $error("Protocol id or length high not zero.");
   property p_len; r_valid && r_last |-> rc_q == {1'b0, ln_q} + 9'h005; endproperty
   a_len: assert property (p_len) else $error("Length does not match the frame.");
   property p_unit; r_valid && rc_q == 9'h006 |-> r_data == qb_q[6] && (r_data == UNIT_ANY || r_data == UNIT_ALL); endproperty
   a_unit: assert property (p_unit) else $error("Unit id wrong.");
   property p_echo; r_valid && qb_q[7] == FC_WRITE && rc_q < 9'h00C |-> r_data == qb_q[rc_q[3:0]]; endproperty
   a_echo: assert property (p_echo) else $error("Write answer differs from query.");
   property p_wlen; r_valid && r_last && qb_q[7] == FC_WRITE |-> rc_q == 9'h00B; endproperty
   a_wlen: assert property (p_wlen) else $error("Write answer not twelve bytes.");
   property p_bcnt; r_valid && rc_q == 9'h008 && qb_q[7] == FC_READ |-> r_data == ln_q - 8'h03 && r_data inside {[2:250]}; endproperty
   a_bcnt: assert property (p_bcnt) else $error("Byte count wrong.");
   property p_late; $rose(r_valid) |-> $past(q_valid && q_ready, 2); endproperty
   a_late: assert property (p_late) else $error("Answer not two cycles after query.");
   c_wr: cover property (r_valid && r_last && qb_q[7] == FC_WRITE);
   c_rd: cover property (r_valid && r_last && qb_q[7] == FC_READ);
   c_big: cover property (r_valid && rc_q == 9'h100);
endmodule

// >>> tb/modbus_tcp_register_server_tb.sv
// Bench joining master and server ends.
`timescale 1ns/1ps
module modbus_tcp_register_server_tb;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic rq_v = 1'b0;
   logic rq_w = 1'b0;
   logic [15:0] rq_t = 16'h0000;
   logic [7:0] rq_u = 8'h00;
   logic [15:0] rq_r = 16'h0000;
   logic [15:0] rq_x = 16'h0000;
   logic rdy, rs_v, rs_l, ws;
   logic [7:0] rs_d;
   logic [15:0] wa, wd;
   int error_cnt = 0;
   int n_tests = 0;
   int cyc = 0;
   int nws = 0;
   logic [7:0] rb [$];
   mbt_if aif ();
   mbt_if bif ();
   always #5 sys_clk = ~sys_clk;
   mbt_server mbt_server_inst (.sys_clk(sys_clk), .reset(reset), .link(aif), .wr_strobe(ws), .wr_addr(wa),
      .wr_data(wd));
   // The second server faces the bench, so malformed queries can reach it.
   mbt_server mbt_server_inst2 (.sys_clk(sys_clk), .reset(reset), .link(bif), .wr_strobe(), .wr_addr(),
      .wr_data());
   mbt_master mbt_master_inst (.sys_clk(sys_clk), .reset(reset), .link(aif), .req_valid(rq_v), .req_ready(rdy),
      .req_write(rq_w), .req_tid(rq_t), .req_unit(rq_u), .req_reg(rq_r), .req_val(rq_x), .rsp_data(rs_d),
      .rsp_valid(rs_v), .rsp_last(rs_l));
   mbt_assertions mbt_assertions_inst (.sys_clk(sys_clk), .reset(reset), .q_data(aif.q_data),
      .q_valid(aif.q_valid), .q_ready(aif.q_ready), .r_data(aif.r_data), .r_valid(aif.r_valid),
      .r_last(aif.r_last), .r_ready(aif.r_ready));
   // Count write pulses on the falling edge, where they are settled.
   always @(negedge sys_clk) if (ws === 1'b1) nws++;
   // ********
   // Tasks
   // ********
   task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
      n_tests++;
      if (s !== e) begin
         error_cnt++;
         $display("FAIL %s exp %h seen %h", nm, e, s);
      end
   endtask
   // One query through the master; hangs are cut short by the cycle ceiling.
   task run(input logic w, input logic [15:0] t, input logic [7:0] u, input logic [15:0] r, input logic [15:0] x);
      rb = {};
      @(negedge sys_clk);
      rq_v = 1'b1;
      rq_w = w;
      rq_t = t;
      rq_u = u;
      rq_r = r;
      rq_x = x;
      while (rdy !== 1'b1) @(negedge sys_clk);
      @(negedge sys_clk);
      rq_v = 1'b0;
      do begin
         @(negedge sys_clk);
         if (rs_v === 1'b1) rb.push_back(rs_d);
      end while (!(rs_v === 1'b1 && rs_l === 1'b1));
   endtask
   task cmp(input string nm, input logic [7:0] e [$]);
      chk(nm, 16'(rb.size()), 16'(e.size()));
      foreach (e[i]) chk(nm, {8'h00, rb[i]}, {8'h00, e[i]});
   endtask
   task t_write;
      int n;
      n = nws;
      run(1'b1, 16'h1234, 8'hFF, 16'h9C4E, 16'h1770); // Register 40014.
      cmp("wr echo", '{8'h12, 8'h34, 8'h00, 8'h00, 8'h00, 8'h06, 8'hFF, 8'h06, 8'h00, 8'h0D,
         8'h17, 8'h70});
      chk("wr pulse", 16'(nws - n), 16'h0001);
      chk("wr addr", wa, 16'h000D);
      chk("wr data", wd, 16'h1770);
      chk("idle ready", {15'h0000, rdy}, 16'h0001);
      $display("test write done");
   endtask
   task t_read;
      run(1'b1, 16'h0002, 8'h00, 16'h9C4F, 16'h0BB8);
      run(1'b1, 16'h0003, 8'h00, 16'h9C50, 16'h03E8);
      run(1'b0, 16'hABCD, 8'h00, 16'h9C4E, 16'h0003);
      cmp("rd", '{8'hAB, 8'hCD, 8'h00, 8'h00, 8'h00, 8'h09, 8'h00, 8'h03, 8'h06, 8'h17, 8'h70,
         8'h0B, 8'hB8, 8'h03, 8'hE8});
      $display("test read done");
   endtask
   task t_max;
      run(1'b0, 16'h0007, 8'hFF, 16'h9C41, 16'h007D);
      chk("max size", 16'(rb.size()), 16'h0103);
      chk("max len", {8'h00, rb[5]}, 16'h00FD);
      chk("max count", {8'h00, rb[8]}, 16'h00FA);
      chk("max reg13", {rb[35], rb[36]}, 16'h1770);
      $display("test max read done");
   endtask
   task t_refuse;
      logic [95:0] f [7];
      int k;
      f = '{96'h0001_0001_0006_FF06_0001_0002, 96'h0001_0000_0006_0106_0001_0002,
            96'h0001_0000_0006_FF03_0000_007E, 96'h0001_0000_0006_0006_0001_0002,
            96'h0001_0000_0005_FF06_0001_0002, 96'h0001_0000_0006_FF03_0000_0000,
            96'h0001_0000_0006_FF06_0100_0002};
      for (int j = 0; j < 7; j++) begin
         for (int i = 0; i < 12; i++) begin
            @(negedge sys_clk);
            bif.q_data = f[j][95 - 8 * i -: 8];
            bif.q_valid = 1'b1;
            while (bif.q_ready !== 1'b1) @(negedge sys_clk);
         end
         @(negedge sys_clk);
         bif.q_valid = 1'b0;
         k = 0;
         repeat (40) begin
            @(negedge sys_clk);
            if (bif.r_valid === 1'b1) k++;
         end
         chk("answer bytes", 16'(k), (j == 3) ? 16'h000C : 16'h0000);
      end
      $display("test refuse done");
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // The whole run needs well under a thousand cycles.
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         give_verdict;
      end
   end
   initial begin
      bif.q_valid = 1'b0;
      bif.q_data = 8'h00;
      bif.r_ready = 1'b1;
      repeat (6) @(negedge sys_clk);
      reset = 1'b0;
      t_write;
      t_read;
      t_max;
      t_refuse;
      give_verdict;
   end
endmodule
